// *** rtl/selfprog_pkg.sv ***
package selfprog_pkg;

   // ********************************************************************
   // Register addresses
   // ********************************************************************
   localparam logic [7:0] ctrl_data_offset = 8'h57;
   localparam logic [7:0] io_window_base   = 8'h20;
   localparam logic [5:0] ctrl_io_offset   = 6'h37;
   localparam logic [7:0] ctrl_reset       = 8'h00;

   // ********************************************************************
   // Control bit positions
   // ********************************************************************
   localparam int bit_ready_ie   = 7;
   localparam int bit_rww_busy   = 6;
   localparam int bit_sig_read   = 5;
   localparam int bit_rww_ren    = 4;
   localparam int bit_lock_set   = 3;
   localparam int bit_page_write = 2;
   localparam int bit_page_erase = 1;
   localparam int bit_store_en   = 0;

   // ********************************************************************
   // Accepted command patterns in the low five bits
   // ********************************************************************
   localparam logic [4:0] cmd_rww_enable = 5'h11;
   localparam logic [4:0] cmd_lock_set   = 5'h09;
   localparam logic [4:0] cmd_page_write = 5'h05;
   localparam logic [4:0] cmd_page_erase = 5'h03;
   localparam logic [4:0] cmd_page_load  = 5'h01;
   localparam logic [4:0] cmd_sig_read   = 5'h01;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam logic [2:0] arm_cycles     = 3'h4;
   localparam logic [2:0] load_arm_cycles = 3'h3;

   // ********************************************************************
   // Memory-size variants
   // ********************************************************************
   localparam int words_4k = 4096;
   localparam int words_8k = 8192;

   // Boot start per fuse code 11,10,01,00
   localparam logic [12:0] boot_start_4k_11 = 13'h0f80;
   localparam logic [12:0] boot_start_4k_10 = 13'h0f00;
   localparam logic [12:0] boot_start_4k_01 = 13'h0e00;
   localparam logic [12:0] boot_start_4k_00 = 13'h0c00;
   localparam logic [12:0] boot_start_8k_11 = 13'h1f80;
   localparam logic [12:0] boot_start_8k_10 = 13'h1f00;
   localparam logic [12:0] boot_start_8k_01 = 13'h1e00;
   localparam logic [12:0] boot_start_8k_00 = 13'h1c00;
   localparam logic [12:0] flash_top_4k     = 13'h0fff;
   localparam logic [12:0] flash_top_8k     = 13'h1fff;
   localparam logic [12:0] blocked_start_4k = 13'h0c00;
   localparam logic [12:0] blocked_start_8k = 13'h1c00;

   // Counter and page widths
   localparam int counter_top_bit_4k   = 11;
   localparam int counter_top_bit_8k   = 12;
   localparam int page_word_top_bit_4k = 4;
   localparam int page_word_top_bit_8k = 5;

   typedef enum logic [2:0] {
      op_none,
      op_page_load,
      op_page_erase,
      op_page_write,
      op_lock_set,
      op_rww_enable
   } op_t;

endpackage : selfprog_pkg

// *** rtl/section_map.sv ***
`timescale 1ns/1ns
// ************************************************************************
// Fuse-driven section boundaries
// ************************************************************************
module section_map #(
   parameter bit large_variant = 1'b0
) (
   // Fuses
   input  wire logic [1:0]  boot_size,
   // Address under test
   input  wire logic [12:0] word_addr,
   // Boundaries
   output logic      [12:0] boot_start,
   output logic      [12:0] app_end,
   output logic      [12:0] flash_top,
   output logic             in_boot,
   output logic             in_blocked_area
);

   wire [12:0] blocked_start;

   always_comb begin
      if (large_variant) begin
         case (boot_size)
            2'b11:   boot_start = selfprog_pkg::boot_start_8k_11;
            2'b10:   boot_start = selfprog_pkg::boot_start_8k_10;
            2'b01:   boot_start = selfprog_pkg::boot_start_8k_01;
            default: boot_start = selfprog_pkg::boot_start_8k_00;
         endcase
      end else begin
         case (boot_size)
            2'b11:   boot_start = selfprog_pkg::boot_start_4k_11;
            2'b10:   boot_start = selfprog_pkg::boot_start_4k_10;
            2'b01:   boot_start = selfprog_pkg::boot_start_4k_01;
            default: boot_start = selfprog_pkg::boot_start_4k_00;
         endcase
      end
   end

   assign app_end         = boot_start - 13'h0001;
   assign flash_top       = large_variant ? selfprog_pkg::flash_top_8k
                                          : selfprog_pkg::flash_top_4k;
   assign blocked_start   = large_variant ? selfprog_pkg::blocked_start_8k
                                          : selfprog_pkg::blocked_start_4k;
   assign in_boot         = (word_addr >= boot_start) && (word_addr <= flash_top);
   assign in_blocked_area = (word_addr >= blocked_start) && (word_addr <= flash_top);

endmodule : section_map

// *** rtl/pointer_decode.sv ***
`timescale 1ns/1ns
// ************************************************************************
// Pointer split into page, word and byte fields
// ************************************************************************
module pointer_decode #(
   parameter bit large_variant = 1'b0
) (
   // Pointer
   input  wire logic [15:0] pointer,
   // Fields
   output logic      [6:0]  page_select_field,
   output logic      [5:0]  word_select_field,
   output logic      [12:0] word_addr,
   output logic             byte_select
);

   // Bits above the counter mapping never reach any output
   assign page_select_field = large_variant ? pointer[13:7] : pointer[12:6];
   assign word_select_field = large_variant ? pointer[6:1]
                                            : {1'b0, pointer[5:1]};
   assign word_addr         = large_variant ? pointer[13:1]
                                            : {1'b0, pointer[12:1]};
   assign byte_select       = pointer[0];

endmodule : pointer_decode

// *** rtl/selfprog_ctrl.sv ***
`timescale 1ns/1ns
// What this block does
// - 4K variant: boot start F80/F00/E00/C00 per fuse, ends FFF, app ends below.
// - 8K variant: boot start 1F80/1F00/1E00/1C00 per fuse, ends 1FFF.
// - 4K variant: 000-BFF readable during programming, C00-FFF blocked.
// - 8K variant: 0000-1BFF readable during programming, 1C00-1FFF blocked.
// - 4K variant program counter is 12 bits wide.
// - 4K variant page holds 32 words, low 5 counter bits.
// - 8K variant program counter is 13 bits wide.
// - 8K variant page holds 64 words, low 6 counter bits.
// - Page number from pointer 12:6 (4K) or 13:7 (8K).
// - Buffer word from pointer 5:1 or 6:1; zero during page write.
// - Pointer bit 0 is byte select for loads and stores alike, never forced to zero.
// - Pointer bits above the counter mapping are ignored.
// - Control register at data offset 0x57, resets to zero.
// - I/O address is data offset minus 0x20, giving 0x37.
// - Bit order: irq enable, busy, sig read, rww enable, lock, write, erase, store.
// - Busy sets on area erase/write; clears on rww enable or page load.
// - Store enable arms one store for four cycles; holds during erase/write.
// - Erase/write take page from pointer; command clears on done or timeout.
// - Only listed command patterns in the low five bits take effect.
module selfprog_ctrl #(
   parameter bit large_variant = 1'b0
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Fuses
   input  wire logic [1:0]  boot_size,
   // Data-space register port
   input  wire logic [7:0]  data_addr,
   input  wire logic        data_wr,
   input  wire logic        data_rd,
   input  wire logic [7:0]  data_wdata,
   // I/O register port
   input  wire logic [5:0]  io_addr,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  reg_rdata,
   // Core instructions
   input  wire logic        store_exec,
   input  wire logic        load_exec,
   input  wire logic [15:0] pointer,
   // Flash array
   input  wire logic        flash_done,
   output logic             flash_start,
   output logic [2:0]       flash_op,
   output logic [6:0]       flash_page,
   output logic [5:0]       flash_word,
   output logic             flash_byte_sel,
   output logic             target_blocked_area,
   output logic             target_boot,
   output logic [12:0]      boot_start_out,
   output logic             cpu_halt,
   output logic             special_load
);

   // ********************************************************************
   // Register state
   // ********************************************************************
   logic [7:0]  ctrl;
   logic [2:0]  arm_count;
   logic        busy_op;
   logic        blocked_op;
   logic        load_window;

   wire [6:0]   page_f;
   wire [5:0]   word_f;
   wire [12:0]  word_addr;
   wire         byte_f;
   wire [12:0]  boot_start;
   wire [12:0]  app_end;
   wire [12:0]  flash_top;
   wire         in_boot;
   wire         in_blocked;

   // ********************************************************************
   // Decoders
   // ********************************************************************
   pointer_decode #(.large_variant(large_variant)) u_ptr (
      .pointer           (pointer),
      .page_select_field (page_f),
      .word_select_field (word_f),
      .word_addr         (word_addr),
      .byte_select       (byte_f)
   );

   section_map #(.large_variant(large_variant)) u_map (
      .boot_size       (boot_size),
      .word_addr       (word_addr),
      .boot_start      (boot_start),
      .app_end         (app_end),
      .flash_top       (flash_top),
      .in_boot         (in_boot),
      .in_blocked_area (in_blocked)
   );

   // ********************************************************************
   // Register access decode
   // ********************************************************************
   wire         hit_data = data_addr == selfprog_pkg::ctrl_data_offset;
   wire [7:0]   io_as_data = {2'b00, io_addr} + selfprog_pkg::io_window_base;
   wire         hit_io   = (io_addr == selfprog_pkg::ctrl_io_offset)
                           && (io_as_data == selfprog_pkg::ctrl_data_offset);
   wire         wr_hit   = (data_wr && hit_data) || (io_wr && hit_io);
   wire         rd_hit   = (data_rd && hit_data) || (io_rd && hit_io);
   wire [7:0]   wdata    = (io_wr && hit_io) ? io_wdata : data_wdata;
   wire [4:0]   wcmd     = wdata[4:0];
   wire         armed    = ctrl[selfprog_pkg::bit_store_en] && !busy_op;

   function automatic logic legal_cmd(input logic [4:0] c);
      legal_cmd = (c == selfprog_pkg::cmd_rww_enable) || (c == selfprog_pkg::cmd_lock_set)
               || (c == selfprog_pkg::cmd_page_write) || (c == selfprog_pkg::cmd_page_erase)
               || (c == selfprog_pkg::cmd_page_load);
   endfunction : legal_cmd

   // Writes during a running erase/write cannot rearm
   wire         cmd_ok   = wr_hit && !busy_op && legal_cmd(wcmd);
   wire [4:0]   cur_cmd  = ctrl[4:0];
   wire         sig_mode = ctrl[selfprog_pkg::bit_sig_read];

   // ********************************************************************
   // Store decode
   // ********************************************************************
   wire         do_store = armed && store_exec && !sig_mode;
   wire         do_erase = do_store && (cur_cmd == selfprog_pkg::cmd_page_erase);
   wire         do_write = do_store && (cur_cmd == selfprog_pkg::cmd_page_write);
   wire         do_load  = do_store && (cur_cmd == selfprog_pkg::cmd_page_load);
   wire         do_lock  = do_store && (cur_cmd == selfprog_pkg::cmd_lock_set);
   wire         do_rwwen = do_store && (cur_cmd == selfprog_pkg::cmd_rww_enable);
   wire         long_op  = do_erase || do_write;
   wire         timeout  = armed && !do_store && (arm_count == 3'h1);
   wire         load_to  = armed && (arm_count == selfprog_pkg::arm_cycles
                                    - selfprog_pkg::load_arm_cycles + 3'h1);

   logic [2:0]  next_op;
   always_comb begin
      if (do_erase)      next_op = selfprog_pkg::op_page_erase;
      else if (do_write) next_op = selfprog_pkg::op_page_write;
      else if (do_load)  next_op = selfprog_pkg::op_page_load;
      else if (do_lock)  next_op = selfprog_pkg::op_lock_set;
      else if (do_rwwen) next_op = selfprog_pkg::op_rww_enable;
      else               next_op = selfprog_pkg::op_none;
   end

   // ********************************************************************
   // Control register
   // ********************************************************************
   logic [7:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      if (wr_hit) begin
         next_ctrl[selfprog_pkg::bit_ready_ie] = wdata[selfprog_pkg::bit_ready_ie];
      end
      if (cmd_ok) begin
         next_ctrl[5:0] = {wdata[selfprog_pkg::bit_sig_read], wcmd};
         next_ctrl[selfprog_pkg::bit_rww_busy] = ctrl[selfprog_pkg::bit_rww_busy];
      end
      if ((do_store && !long_op) || timeout || (busy_op && flash_done)) begin
         next_ctrl[5:0] = 6'h00;
      end
      if (sig_mode && armed && (load_exec || load_to)) begin
         next_ctrl[5:0] = 6'h00;
      end
      // Busy: set on erase/write of the readable area, cleared by page load
      if (do_load || (do_rwwen && !busy_op)) begin
         next_ctrl[selfprog_pkg::bit_rww_busy] = 1'b0;
      end
      if (long_op && !in_blocked) begin
         next_ctrl[selfprog_pkg::bit_rww_busy] = 1'b1;
      end
      if (busy_op && flash_done) begin
         next_ctrl[selfprog_pkg::bit_rww_busy] = ctrl[selfprog_pkg::bit_rww_busy];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= selfprog_pkg::ctrl_reset;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ********************************************************************
   // Arm window and operation tracking
   // ********************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arm_count <= 3'h0;
      end else if (cmd_ok && wdata[selfprog_pkg::bit_store_en]) begin
         arm_count <= selfprog_pkg::arm_cycles;
      end else if (armed && arm_count != 3'h0) begin
         arm_count <= arm_count - 3'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_op    <= 1'b0;
         blocked_op <= 1'b0;
      end else if (long_op) begin
         busy_op    <= 1'b1;
         blocked_op <= in_blocked;
      end else if (flash_done) begin
         busy_op    <= 1'b0;
         blocked_op <= 1'b0;
      end
   end

   // Loads count in the first three armed cycles only
   assign load_window = armed && (sig_mode || cur_cmd == selfprog_pkg::cmd_lock_set)
                        && (arm_count > selfprog_pkg::arm_cycles
                                        - selfprog_pkg::load_arm_cycles);

   // ********************************************************************
   // Outputs
   // ********************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata           <= 8'h00;
         flash_start         <= 1'b0;
         flash_op            <= 3'h0;
         flash_page          <= 7'h00;
         flash_word          <= 6'h00;
         flash_byte_sel      <= 1'b0;
         target_blocked_area <= 1'b0;
         target_boot         <= 1'b0;
         boot_start_out      <= 13'h0000;
         cpu_halt            <= 1'b0;
         special_load        <= 1'b0;
      end else begin
         reg_rdata           <= rd_hit ? ctrl : 8'h00;
         flash_start         <= do_store;
         flash_op            <= next_op;
         flash_page          <= page_f;
         flash_word          <= (do_write || do_erase) ? 6'h00 : word_f;
         flash_byte_sel      <= byte_f;
         target_blocked_area <= in_blocked;
         target_boot         <= in_boot;
         boot_start_out      <= boot_start;
         cpu_halt            <= (long_op && in_blocked) || (blocked_op && !flash_done);
         special_load        <= load_window && load_exec;
      end
   end

endmodule : selfprog_ctrl

// *** sim/flash_array_model.sv ***
`timescale 1ns/1ns
// ************************************************************************
// Flash array: ends erase, write and lock operations after a busy time
// ************************************************************************
module flash_array_model #(
   parameter int busy_cycles = 12
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Operation request and completion
   input  wire logic       flash_start,
   input  wire logic [2:0] flash_op,
   output logic            flash_done
);
   int left;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left       <= 0;
         flash_done <= 1'b0;
      end else begin
         flash_done <= (left == 1);
         if (flash_start && flash_op inside {selfprog_pkg::op_page_erase,
               selfprog_pkg::op_page_write, selfprog_pkg::op_lock_set}) begin
            left <= busy_cycles;
         end else if (left != 0) begin
            left <= left - 1;
         end
      end
   end
endmodule : flash_array_model

// *** sim/selfprog_ctrl_properties.sv ***
`timescale 1ns/1ns
module selfprog_ctrl_properties #(
   parameter bit large_variant = 1'b0
) (
   // Clock, reset, fuses
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  boot_size,
   // Register port
   input  wire logic        data_rd,
   input  wire logic        io_rd,
   input  wire logic [7:0]  reg_rdata,
   // Core and array
   input  wire logic        store_exec,
   input  wire logic [15:0] pointer,
   input  wire logic        flash_done,
   input  wire logic        flash_start,
   input  wire logic [2:0]  flash_op,
   input  wire logic [6:0]  flash_page,
   input  wire logic [5:0]  flash_word,
   input  wire logic        target_blocked_area,
   input  wire logic        target_boot,
   input  wire logic [12:0] boot_start_out,
   input  wire logic        cpu_halt
);
   logic [15:0] ptr_q;
   logic [1:0]  size_q;
   logic [1:0]  steady;
   logic [12:0] wa;
   logic [12:0] exp_start;
   logic        settled;
   assign wa        = large_variant ? pointer[13:1] : {1'b0, pointer[12:1]};
   assign exp_start = (large_variant ? 13'h0000 : 13'h1000) - (13'h0400 >> boot_size);
   always_ff @(posedge clk) begin
      ptr_q  <= pointer;
      size_q <= boot_size;
   end
   // Cycles for which pointer and fuses have held still
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         steady <= 2'h0;
      end else if (pointer != ptr_q || boot_size != size_q) begin
         steady <= 2'h0;
      end else if (steady != 2'h3) begin
         steady <= steady + 2'h1;
      end
   end
   // Map outputs only hold once pointer and fuses stood still
   assign settled = steady >= 2'h2 && pointer == ptr_q && boot_size == size_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_boot_start;
      settled |-> boot_start_out == exp_start;
   endproperty
   a_boot_start: assert property (p_boot_start) else $error("boot start wrong");
   property p_blocked;
      settled |-> target_blocked_area == (wa >= (large_variant ? 13'h1c00 : 13'h0c00));
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked area flag wrong");
   property p_boot_hit;
      settled |-> target_boot == (wa >= exp_start);
   endproperty
   a_boot_hit: assert property (p_boot_hit) else $error("boot target flag wrong");
   property p_page;
      flash_start && (flash_op == selfprog_pkg::op_page_erase
                      || flash_op == selfprog_pkg::op_page_write) |->
         flash_word == 6'h00 && flash_page == (large_variant ? ptr_q[13:7] : ptr_q[12:6]);
   endproperty
   a_page: assert property (p_page) else $error("page field wrong");
   property p_load_word;
      flash_start && flash_op == selfprog_pkg::op_page_load |->
         flash_word == (large_variant ? ptr_q[6:1] : {1'b0, ptr_q[5:1]});
   endproperty
   a_load_word: assert property (p_load_word) else $error("load word field wrong");
   property p_start;
      flash_start |-> $past(store_exec);
   endproperty
   a_start: assert property (p_start) else $error("start without store");
   property p_rdata;
      !$past(data_rd) && !$past(io_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data without read");
   property p_halt_rise;
      $rose(cpu_halt) |-> flash_start || $past(flash_start);
   endproperty
   a_halt_rise: assert property (p_halt_rise) else $error("halt without start");
   property p_halt_end;
      $fell(cpu_halt) |-> $past(flash_done) || $past(flash_done, 2);
   endproperty
   a_halt_end: assert property (p_halt_end) else $error("halt ended early");
endmodule : selfprog_ctrl_properties
bind selfprog_ctrl selfprog_ctrl_properties #(.large_variant(large_variant)) props_inst (
   .clk(clk), .rst(rst), .boot_size(boot_size), .data_rd(data_rd), .io_rd(io_rd),
   .reg_rdata(reg_rdata), .store_exec(store_exec), .pointer(pointer),
   .flash_done(flash_done), .flash_start(flash_start), .flash_op(flash_op),
   .flash_page(flash_page), .flash_word(flash_word), .target_boot(target_boot),
   .target_blocked_area(target_blocked_area), .boot_start_out(boot_start_out),
   .cpu_halt(cpu_halt));

// *** sim/test_selfprog_ctrl.sv ***
`timescale 1ns/1ns
module test_selfprog_ctrl;
   logic        clk, rst, data_wr, data_rd, io_wr, io_rd, store_exec, load_exec;
   logic        flash_done, flash_start, flash_byte_sel, target_blocked_area;
   logic        target_boot, cpu_halt, special_load;
   logic [1:0]  boot_size;
   logic [2:0]  flash_op;
   logic [5:0]  io_addr, flash_word;
   logic [6:0]  flash_page;
   logic [7:0]  data_addr, data_wdata, io_wdata, reg_rdata;
   logic [12:0] boot_start_out;
   logic [15:0] pointer;
   logic [12:0] boot_tab [4] = '{13'h0c00, 13'h0e00, 13'h0f00, 13'h0f80};
   int          fails, n_tests, i, k;
   selfprog_ctrl #(.large_variant(1'b0)) selfprog_ctrl_inst (.clk(clk), .rst(rst),
      .boot_size(boot_size), .data_addr(data_addr), .data_wr(data_wr), .data_rd(data_rd),
      .data_wdata(data_wdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .reg_rdata(reg_rdata), .store_exec(store_exec),
      .load_exec(load_exec), .pointer(pointer), .flash_done(flash_done),
      .flash_start(flash_start), .flash_op(flash_op), .flash_page(flash_page),
      .flash_word(flash_word), .flash_byte_sel(flash_byte_sel),
      .target_blocked_area(target_blocked_area), .target_boot(target_boot),
      .boot_start_out(boot_start_out), .cpu_halt(cpu_halt), .special_load(special_load));
   flash_array_model flash_array_model_inst (.clk(clk), .rst(rst),
      .flash_start(flash_start), .flash_op(flash_op), .flash_done(flash_done));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One register access, either strobe pair
   task automatic acc(input bit io, input bit wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      data_addr  <= a;
      io_addr    <= a[5:0];
      data_wdata <= d;
      io_wdata   <= d;
      data_wr    <= wr & !io;
      io_wr      <= wr & io;
      data_rd    <= !wr & !io;
      io_rd      <= !wr & io;
      @(posedge clk);
      {data_wr, io_wr, data_rd, io_rd} <= 4'h0;
      #1;
   endtask : acc
   task automatic wr(input bit io, input logic [7:0] a, input logic [7:0] d,
                     input logic [15:0] p);
      @(posedge clk);
      pointer <= p;
      acc(io, 1'b1, a, d);
   endtask : wr
   task automatic rd(input bit io, input logic [7:0] a, input logic [7:0] exp);
      acc(io, 1'b0, a, 8'h00);
      chk(reg_rdata, exp);
   endtask : rd
   task automatic store(input logic [2:0] op);
      @(posedge clk);
      store_exec <= 1'b1;
      @(posedge clk);
      store_exec <= 1'b0;
      #1;
      chk(flash_start, 1'b1);
      chk(flash_op, op);
   endtask : store
   task automatic wait_done();
      for (k = 0; k < 200 && flash_done !== 1'b1; k++) begin
         @(posedge clk);
      end
      if (k == 200) begin
         fails++;
         $display("unexpected at %0t: flash operation never ended", $time);
         test_done();
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : wait_done
   task automatic test_done();
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   initial begin
      {rst, data_wr, data_rd, io_wr, io_rd, store_exec, load_exec} = 7'h40;
      {boot_size, data_addr, data_wdata, io_addr, io_wdata, pointer} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(0, 8'h57, 8'h00);
      rd(1, 8'h37, 8'h00);
      wr(0, 8'h57, 8'h80, 16'h0000);
      rd(1, 8'h37, 8'h80);
      wr(0, 8'h37, 8'h01, 16'h0000);
      rd(0, 8'h56, 8'h00);
      rd(0, 8'h57, 8'h80);
      wr(1, 8'h37, 8'h87, 16'h0000);
      rd(0, 8'h57, 8'h80);
      wr(0, 8'h57, 8'h85, 16'h0000);
      repeat (6) @(posedge clk);
      rd(0, 8'h57, 8'h80);
      for (i = 0; i < 2; i++) begin
         wr(0, 8'h57, i ? 8'h85 : 8'h83, 16'he140);
         store(i ? selfprog_pkg::op_page_write : selfprog_pkg::op_page_erase);
         chk(flash_page, 7'h05);
         chk(flash_word, 6'h00);
         rd(0, 8'h57, i ? 8'hc5 : 8'hc3);
         wait_done();
         rd(0, 8'h57, 8'hc0);
         wr(0, 8'h57, i ? 8'h91 : 8'h81, 16'h0016);
         store(i ? selfprog_pkg::op_rww_enable : selfprog_pkg::op_page_load);
         chk(flash_word, 6'h0b);
         chk(flash_byte_sel, 1'b0);
         rd(0, 8'h57, 8'h80);
      end
      wr(0, 8'h57, 8'h03, 16'h1800);
      store(selfprog_pkg::op_page_erase);
      rd(0, 8'h57, 8'h03);
      chk(cpu_halt, 1'b1);
      chk(target_blocked_area, 1'b1);
      wait_done();
      chk(cpu_halt, 1'b0);
      rd(0, 8'h57, 8'h00);
      wr(0, 8'h57, 8'h09, 16'h0000);
      store(selfprog_pkg::op_lock_set);
      rd(0, 8'h57, 8'h00);
      wait_done();
      for (i = 0; i < 2; i++) begin
         wr(0, 8'h57, 8'h21, 16'h0000);
         repeat (2 * i) @(posedge clk);
         @(posedge clk);
         load_exec <= 1'b1;
         @(posedge clk);
         load_exec <= 1'b0;
         #1;
         chk(special_load, !i);
         rd(0, 8'h57, 8'h00);
      end
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         boot_size <= i[1:0];
         pointer   <= {2'b00, boot_tab[i] - 13'h0001, 1'b0};
         repeat (3) @(posedge clk);
         #1;
         chk(boot_start_out, boot_tab[i]);
         chk(target_boot, 1'b0);
         chk(target_blocked_area, i != 0);
         @(posedge clk);
         pointer <= {2'b00, boot_tab[i], 1'b0};
         repeat (3) @(posedge clk);
         #1;
         chk(target_boot, 1'b1);
      end
      test_done();
   end
endmodule : test_selfprog_ctrl
